// ---- host_model.sv ----
// host_model.sv: host controller that starts the current monitor and reads the diagnosis word
// assumes it shares i_clock with the monitor and is driven through its tasks
`default_nettype none
module host_model
   import protmon_pkg::*;
(
   // clock
   input  wire logic        i_clock,
   // device side
   input  wire logic [6:0]  i_word,
   input  wire logic        i_done,
   input  wire mon_result_t i_result,
   // host requests
   output logic             o_monitor_start,
   output logic             o_diag_read_done
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      o_monitor_start  = 1'b0;
      o_diag_read_done = 1'b0;
   end

   // one completed read: the word is taken while settled, the pulse is seen by the next edge
   task automatic read_diag(output logic [6:0] w);
      @(negedge i_clock);
      w = i_word;
      o_diag_read_done = 1'b1;
      @(negedge i_clock);
      o_diag_read_done = 1'b0;
   endtask

   // results are taken once done is polled high, or after 64 edges without it; the first edges may still show the old done
   task automatic start_monitor(output mon_result_t res, output int n, output logic mid);
      logic seen;
      seen = 1'b0;
      mid  = 1'b0;
      n    = 0;
      @(negedge i_clock);
      o_monitor_start = 1'b1;
      while (n < 64 && !seen)
      begin
         @(negedge i_clock);
         n++;
         if (n == 2)
            mid = i_done;
         seen = (n > 2) && (i_done === 1'b1);
      end
      res = i_result;
      o_monitor_start = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- protection_diagnostic_monitor.sv ----
// protection_diagnostic_monitor.sv: fault filtering, brake control, diagnosis word
// and current monitor for a dc/dc led controller
// assumes sense comparators and serial front end are synchronous to i_clock
`include "protmon_map.svh"
`default_nettype none
module protection_diagnostic_monitor
   import protmon_pkg::*;
#(
   parameter int SHORT_CYCLES  = `SHORT_FILTER_CYCLES,
   parameter int SETTLE_CYCLES = `MON_SETTLE_CYCLES
)
(
   // clock and reset
   input  wire logic                   i_clock,
   input  wire logic                   i_rst_b,
   // analog sense comparators
   input  wire sense_t                 i_sense,
   input  wire logic                   i_softstart_above_level,
   input  wire logic                   i_idle,
   input  wire logic [1:0]             i_input_window,
   input  wire logic [1:0]             i_output_window,
   // control bits from the serial register
   input  wire logic                   i_short_detect_disable,
   input  wire logic                   i_monitor_start,
   input  wire logic                   i_diag_read_done,
   // diagnosis and monitor to the serial register
   output logic [`DIAG_WIDTH-1:0]      o_standard_diagnosis_word,
   output mon_result_t                 o_mon_result,
   output logic                        o_monitor_done,
   // power stage control
   output logic                        o_brake,
   output logic                        o_gate_off,
   output logic                        o_softstart_restart,
   // open-drain led current present pin
   output logic                        o_led_current_present_o,
   output logic                        o_led_current_present_oe
);
   if (SHORT_CYCLES < 1 || SETTLE_CYCLES < 1) $error("protmon: bad counts");

   logic       short_hit;
   logic       short_active;
   logic       ov_active;
   logic       led_present;
   logic       start_q;
   logic       start_pulse;
   logic       in_done;
   logic       out_done;
   logic [1:0] in_res;
   logic [1:0] out_res;
   logic       next_short_flag;
   logic       next_ov_flag;
   logic       short_flag;
   logic       ov_flag;
   logic       tsd_latched;
   logic       fault_brake;
   mon_state_t mon_state;

   // short filter only runs once the soft start has left its blind window
   short_filter #(
      .COUNT    (SHORT_CYCLES)
   ) u_short (
      .i_clock  (i_clock),
      .i_rst_b  (i_rst_b),
      .i_enable (!i_short_detect_disable && i_softstart_above_level && !i_idle),
      .i_below  (i_sense.fbh_below_entry),
      .o_hit    (short_hit)
   );

   // short fault holds until feedback rises above the exit threshold
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         short_active <= 1'b0;
      else if (i_short_detect_disable)
         short_active <= 1'b0;
      else if (short_hit)
         short_active <= 1'b1;
      else if (i_sense.fbh_above_exit)
         short_active <= 1'b0;
   end

   // overvoltage with hysteresis
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         ov_active <= 1'b0;
      else if (i_idle)
         ov_active <= 1'b0;
      else if (i_sense.ov_above_th)
         ov_active <= 1'b1;
      else if (i_sense.ov_below_hys)
         ov_active <= 1'b0;
   end

   assign fault_brake = short_active || ov_active;

   // overtemperature wins: it shuts the drivers instead of braking
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         o_gate_off <= 1'b1;
         o_brake    <= 1'b0;
      end
      else if (i_sense.tsd)
      begin
         o_gate_off <= 1'b1;
         o_brake    <= 1'b0;
      end
      else if (i_sense.gate_uv)
      begin
         o_gate_off <= 1'b1;
         o_brake    <= 1'b0;
      end
      else
      begin
         o_gate_off <= 1'b0;
         o_brake    <= fault_brake;
      end
   end

   // one-cycle restart request when a fault lifts
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         tsd_latched <= 1'b0;
      else
         tsd_latched <= i_sense.tsd || fault_brake || i_sense.gate_uv;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         o_softstart_restart <= 1'b0;
      else
         o_softstart_restart <= tsd_latched && !(i_sense.tsd || fault_brake || i_sense.gate_uv);
   end

   // sticky flags: a new event in the read cycle survives the clear
   always_comb
   begin
      next_short_flag = short_flag;
      next_ov_flag    = ov_flag;
      if (i_diag_read_done)
      begin
         next_short_flag = 1'b0;
         next_ov_flag    = 1'b0;
      end
      if (short_hit && !i_short_detect_disable)
         next_short_flag = 1'b1;
      if (i_sense.ov_above_th && !i_idle)
         next_ov_flag = 1'b1;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         short_flag <= 1'b0;
         ov_flag    <= 1'b0;
      end
      else
      begin
         short_flag <= next_short_flag;
         ov_flag    <= next_ov_flag;
      end
   end

   // led current present comparator with hysteresis
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         led_present <= 1'b0;
      else if (i_sense.ledc_above_inc)
         led_present <= 1'b1;
      else if (i_sense.ledc_below_dec)
         led_present <= 1'b0;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         o_led_current_present_o  <= 1'b0;
         o_led_current_present_oe <= 1'b1;
      end
      else
      begin
         o_led_current_present_o  <= 1'b0;
         o_led_current_present_oe <= !led_present;
      end
   end

   // diagnosis word; idle masks everything but temperature and supplies
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         o_standard_diagnosis_word <= `DIAG_RESET;
      else
      begin
         o_standard_diagnosis_word[`DIAG_BIT_SHORT]    <= next_short_flag && !i_idle;
         o_standard_diagnosis_word[`DIAG_BIT_OV]       <= next_ov_flag && !i_idle;
         o_standard_diagnosis_word[`DIAG_BIT_LED_CURRENT_PRESENT]   <= led_present && !i_idle;
         o_standard_diagnosis_word[`DIAG_BIT_TSD]      <= i_sense.tsd;
         o_standard_diagnosis_word[`DIAG_BIT_TW]       <= i_sense.tw;
         o_standard_diagnosis_word[`DIAG_BIT_GATE_UV]  <= i_sense.gate_uv;
         o_standard_diagnosis_word[`DIAG_BIT_LOGIC_UV] <= i_sense.logic_uv;
      end
   end

   // start bit edge launches both monitors together
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         start_q <= 1'b0;
      else
         start_q <= i_monitor_start;
   end

   assign start_pulse = i_monitor_start && !start_q;

   window_monitor #(
      .SETTLE   (SETTLE_CYCLES)
   ) u_in_mon (
      .i_clock  (i_clock),
      .i_rst_b  (i_rst_b),
      .i_start  (start_pulse),
      .i_window (i_input_window),
      .o_result (in_res),
      .o_done   (in_done)
   );

   window_monitor #(
      .SETTLE   (SETTLE_CYCLES)
   ) u_out_mon (
      .i_clock  (i_clock),
      .i_rst_b  (i_rst_b),
      .i_start  (start_pulse),
      .i_window (i_output_window),
      .o_result (out_res),
      .o_done   (out_done)
   );

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         mon_state <= MON_IDLE;
      else
      begin
         unique case (mon_state)
            MON_IDLE: if (start_pulse) mon_state <= MON_RUN;
            MON_RUN:  if (in_done && out_done) mon_state <= MON_DONE;
            MON_DONE: if (start_pulse) mon_state <= MON_RUN;
            default:  mon_state <= MON_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         o_monitor_done <= 1'b0;
         o_mon_result   <= '0;
      end
      else if (start_pulse)
         o_monitor_done <= 1'b0;
      else if (mon_state == MON_RUN && in_done && out_done)
      begin
         o_monitor_done                     <= 1'b1;
         o_mon_result.input_current_result  <= in_res;
         o_mon_result.output_current_result <= out_res;
      end
   end

   // checks
   short_brakes_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      short_hit && !i_sense.tsd && !i_sense.gate_uv && !i_short_detect_disable
      ##1 !i_sense.tsd && !i_sense.gate_uv |=> o_brake)
      else $error("short did not brake");
   disable_no_brake_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_short_detect_disable [*3] |-> !short_active)
      else $error("short active while disabled");
   softstart_blind_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_softstart_above_level |=> !short_hit)
      else $error("short hit during soft start");
   ov_flag_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_sense.ov_above_th && !i_idle |=> ov_flag)
      else $error("ov flag not set");
   flag_holds_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      short_flag && !i_diag_read_done |=> short_flag)
      else $error("short flag lost without read");
   ov_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      ov_flag && !i_diag_read_done |=> ov_flag)
      else $error("ov flag lost without read");
   tsd_priority_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_sense.tsd |=> o_gate_off && !o_brake)
      else $error("overtemperature not dominant");
   gate_uv_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_sense.gate_uv |=> o_gate_off)
      else $error("gate supply uv did not stop drivers");
   idle_mask_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_idle |=> !o_standard_diagnosis_word[`DIAG_BIT_SHORT] && !o_standard_diagnosis_word[`DIAG_BIT_LED_CURRENT_PRESENT])
      else $error("idle reported masked bit");
   done_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      start_pulse |=> !o_monitor_done [*2])
      else $error("done not cleared by start");
   mirror_led_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_idle |=> o_standard_diagnosis_word[`DIAG_BIT_LED_CURRENT_PRESENT] == !o_led_current_present_oe)
      else $error("led bit does not mirror pin");
   ov_resume_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      ov_active && i_sense.ov_below_hys && !i_sense.ov_above_th |=> !ov_active)
      else $error("ov did not release below hysteresis");
   short_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_sense.fbh_below_entry |=> !short_hit)
      else $error("short hit after sense returned high");

   short_cover_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(o_brake));
   restart_cover_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_softstart_restart);
   monitor_cover_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(o_monitor_done));
   ov_cover_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(ov_active));
   idle_cover_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) i_idle && i_sense.tw);
endmodule
`default_nettype wire

// ---- protection_diagnostic_monitor_bench.sv ----
// protection_diagnostic_monitor_bench.sv: self-checking bench for the protection monitor
// assumes protmon_pkg and host_model are compiled before it
`include "protmon_map.svh"
`default_nettype none
module protection_diagnostic_monitor_bench
   import protmon_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int SC = 8;
   localparam int ST = 4;
   localparam int B_BRK = 7;
   localparam int B_GOFF = 8;
   localparam int B_OE = 9;
   localparam int B_RS = 10;

   logic        i_clock = 1'b0;
   logic        i_rst_b = 1'b0;
   sense_t      sense;
   logic        ss_ok;
   logic        idle;
   logic        sdd;
   logic [1:0]  iw;
   logic [1:0]  ow;
   logic [6:0]  word;
   logic [6:0]  w;
   mon_result_t res;
   mon_result_t r;
   logic        done;
   logic        brake;
   logic        goff;
   logic        rst_p;
   logic        led_o;
   logic        led_oe;
   logic        start;
   logic        rdone;
   logic        hit;
   logic        mid;
   logic [10:0] obs;
   int          fails = 0;
   int          checked = 0;
   int          cycles = 0;
   int          n;

   assign obs = {rst_p, led_oe, goff, brake, word};

   always #25 i_clock = ~i_clock;

   protection_diagnostic_monitor #(.SHORT_CYCLES(SC), .SETTLE_CYCLES(ST)) u_dut (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sense(sense), .i_softstart_above_level(ss_ok),
      .i_idle(idle), .i_input_window(iw), .i_output_window(ow), .i_short_detect_disable(sdd),
      .i_monitor_start(start), .i_diag_read_done(rdone), .o_standard_diagnosis_word(word),
      .o_mon_result(res), .o_monitor_done(done), .o_brake(brake), .o_gate_off(goff),
      .o_softstart_restart(rst_p), .o_led_current_present_o(led_o), .o_led_current_present_oe(led_oe));

   host_model u_host (
      .i_clock(i_clock), .i_word(word), .i_done(done), .i_result(res),
      .o_monitor_start(start), .o_diag_read_done(rdone));

   function automatic logic [6:0] diag_exp(input logic idl, input logic [6:0] raw);
      diag_exp = idl ? (raw & 7'h78) : raw;
   endfunction

   function automatic mon_result_t mon_exp(input logic [1:0] a, input logic [1:0] b);
      mon_exp.input_current_result  = a;
      mon_exp.output_current_result = b;
   endfunction

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge i_clock);
   endtask

   // bounded wait for one observed output to reach a level
   task automatic await(input int b, input logic v, input int lim, output logic h);
      int i;
      h = 1'b0;
      for (i = 0; i < lim && !h; i++)
      begin
         @(negedge i_clock);
         h = (obs[b] === v);
      end
   endtask

   task automatic base();
      sense = '0;
      sense.fbh_above_exit = 1'b1;
      sense.ov_below_hys = 1'b1;
      sense.ledc_below_dec = 1'b1;
   endtask

   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         conclude();
      end
   end

   initial
   begin
      base();
      ss_ok = 1'b1;
      idle = 1'b0;
      sdd = 1'b0;
      iw = 2'h0;
      ow = 2'h0;
      void'($urandom(32'h11B3));
      tick(4);
      check("reset gate off", 8'h01, goff);
      check("reset word", 8'h00, word);
      i_rst_b = 1'b1;
      tick(3);
      check("run gate off", 8'h00, {brake, goff});
      // led present pin with hysteresis band
      sense.ledc_below_dec = 1'b0;
      sense.ledc_above_inc = 1'b1;
      await(B_OE, 1'b0, 4, hit);
      check("led released", 8'h01, hit);
      check("led word bit", 8'h01, word[`DIAG_BIT_LED_CURRENT_PRESENT]);
      check("led drive level", 8'h00, led_o);
      sense.ledc_above_inc = 1'b0;
      tick(4);
      check("led band hold", 8'h00, led_oe);
      sense.ledc_below_dec = 1'b1;
      await(B_OE, 1'b1, 4, hit);
      check("led pulled", 8'h01, hit);
      check("led word clear", 8'h00, word[`DIAG_BIT_LED_CURRENT_PRESENT]);
      // short filter broken one cycle before completing, then a real short
      sense.fbh_above_exit = 1'b0;
      sense.fbh_below_entry = 1'b1;
      tick(SC - 1);
      sense.fbh_below_entry = 1'b0;
      tick(1);
      sense.fbh_below_entry = 1'b1;
      tick(SC - 1);
      check("short early", 8'h00, word[`DIAG_BIT_SHORT]);
      await(`DIAG_BIT_SHORT, 1'b1, SC, hit);
      check("short flag", 8'h01, hit);
      await(B_BRK, 1'b1, 3, hit);
      check("short brake", 8'h01, hit);
      sense.fbh_below_entry = 1'b0;
      sense.fbh_above_exit = 1'b1;
      await(B_RS, 1'b1, 6, hit);
      check("short restart", 8'h01, hit);
      check("short brake off", 8'h00, brake);
      check("short flag stands", 8'h01, word[`DIAG_BIT_SHORT]);
      u_host.read_diag(w);
      check("short read", 8'h01, w[`DIAG_BIT_SHORT]);
      tick(1);
      check("short cleared", 8'h00, word[`DIAG_BIT_SHORT]);
      // short ignored when disabled or during soft start
      for (int m = 0; m < 2; m++)
      begin
         sdd = (m == 0);
         ss_ok = (m == 0);
         sense.fbh_above_exit = 1'b0;
         sense.fbh_below_entry = 1'b1;
         tick(3 * SC);
         check("short ignored", 8'h00, {word[`DIAG_BIT_SHORT], brake, goff});
         base();
         tick(2);
      end
      sdd = 1'b0;
      ss_ok = 1'b1;
      // overvoltage with hysteresis
      sense.ov_below_hys = 1'b0;
      sense.ov_above_th = 1'b1;
      await(`DIAG_BIT_OV, 1'b1, 4, hit);
      check("ov flag", 8'h01, hit);
      await(B_BRK, 1'b1, 3, hit);
      check("ov brake", 8'h01, hit);
      sense.ov_above_th = 1'b0;
      tick(4);
      check("ov hys hold", 8'h01, brake);
      sense.ov_below_hys = 1'b1;
      await(B_BRK, 1'b0, 4, hit);
      check("ov resume", 8'h01, hit);
      check("ov flag stands", 8'h01, word[`DIAG_BIT_OV]);
      u_host.read_diag(w);
      tick(1);
      check("ov cleared", 8'h00, word[`DIAG_BIT_OV]);
      // current monitor: corners first, then random window codes
      for (int k = 0; k < 6; k++)
      begin
         iw = (k == 0) ? 2'h0 : (k == 1) ? 2'h3 : 2'($urandom);
         ow = (k == 0) ? 2'h3 : (k == 1) ? 2'h0 : 2'($urandom);
         u_host.start_monitor(r, n, mid);
         check("done cleared", 8'h00, mid);
         check("done latency", 8'h01, (n > ST) && (n <= ST + 3));
         check("monitor result", 8'(mon_exp(iw, ow)), 8'(r));
      end
      // idle shows only temperature and supply bits
      idle = 1'b1;
      sense.tw = 1'b1;
      sense.logic_uv = 1'b1;
      sense.ledc_below_dec = 1'b0;
      sense.ledc_above_inc = 1'b1;
      tick(4);
      check("idle word", 8'(diag_exp(1'b1, 7'h54)), 8'(word));
      base();
      idle = 1'b0;
      tick(4);
      u_host.read_diag(w);
      // overtemperature wins over a concurrent overvoltage
      sense.tsd = 1'b1;
      sense.ov_below_hys = 1'b0;
      sense.ov_above_th = 1'b1;
      await(B_GOFF, 1'b1, 4, hit);
      check("tsd gate off", 8'h01, hit);
      tick(2);
      check("tsd over brake", 8'h00, brake);
      check("tsd word", 8'h01, word[`DIAG_BIT_TSD]);
      base();
      tick(4);
      u_host.read_diag(w);
      sense.gate_uv = 1'b1;
      await(B_GOFF, 1'b1, 4, hit);
      check("uv gate off", 8'h01, hit);
      check("uv word", 8'h01, word[`DIAG_BIT_GATE_UV]);
      sense.gate_uv = 1'b0;
      await(B_GOFF, 1'b0, 8, hit);
      check("uv gate on", 8'h01, hit);
      // second reset in mid-run
      i_rst_b = 1'b0;
      tick(2);
      check("rerun reset", 8'h01, {word, goff});
      i_rst_b = 1'b1;
      tick(2);
      check("rerun release", 8'h00, {brake, goff});
      conclude();
   end
endmodule
`default_nettype wire

// ---- protmon_map.svh ----
// protmon_map.svh: constants for the protection and diagnostic monitor
// assumes inclusion by bare name from the design files
`ifndef PROTMON_MAP_SVH
`define PROTMON_MAP_SVH
`define SHORT_FILTER_CYCLES 8
`define MON_SETTLE_NS       1000
`define CLOCK_PERIOD_NS     50
`define MON_SETTLE_CYCLES   ((`MON_SETTLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define DIAG_BIT_SHORT      0
`define DIAG_BIT_OV         1
`define DIAG_BIT_LED_CURRENT_PRESENT     2
`define DIAG_BIT_TSD        3
`define DIAG_BIT_TW         4
`define DIAG_BIT_GATE_UV    5
`define DIAG_BIT_LOGIC_UV   6
`define DIAG_WIDTH          7
`define DIAG_RESET          7'h00
`endif

// ---- protmon_pkg.sv ----
// protmon_pkg.sv: types shared by the protection monitor files
// assumes protmon_map.svh sits in the include path
`default_nettype none
package protmon_pkg;
   // analog comparator outcomes, sampled synchronously
   typedef struct packed {
      logic fbh_below_entry;
      logic fbh_above_exit;
      logic ov_above_th;
      logic ov_below_hys;
      logic ledc_above_inc;
      logic ledc_below_dec;
      logic tsd;
      logic tw;
      logic gate_uv;
      logic logic_uv;
   } sense_t;

   typedef struct packed {
      logic [1:0] input_current_result;
      logic [1:0] output_current_result;
   } mon_result_t;

   typedef enum logic [2:0] {
      MON_IDLE = 3'b001,
      MON_RUN  = 3'b010,
      MON_DONE = 3'b100
   } mon_state_t;
endpackage
`default_nettype wire

// ---- short_filter.sv ----
// short_filter.sv: counts consecutive cycles of a low feedback sense
// assumes the below-entry level is synchronous to i_clock
`default_nettype none
module short_filter
#(
   parameter int COUNT = 8
)
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   // control
   input  wire logic i_enable,
   input  wire logic i_below,
   // result
   output logic      o_hit
);
   if (COUNT < 1 || COUNT > 255) $error("short_filter: COUNT out of range");
   logic [7:0] count;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b || !i_enable || !i_below)
      begin
         count <= 8'h00;
         o_hit <= 1'b0;
      end
      else if (count < 8'(COUNT - 1))
      begin
         count <= count + 8'h01;
         o_hit <= 1'b0;
      end
      else
      begin
         o_hit <= 1'b1;
      end
   end

   hit_needs_run_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      $rose(o_hit) |-> $past(i_below, 1) && $past(i_enable, 1))
      else $error("short hit without low sense");
endmodule
`default_nettype wire

// ---- window_monitor.sv ----
// window_monitor.sv: one-shot 2-bit window classification of a sense level
// assumes the window code is presented by the analog comparators
`default_nettype none
module window_monitor
#(
   parameter int SETTLE = 20
)
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   // request
   input  wire logic       i_start,
   input  wire logic [1:0] i_window,
   // result
   output logic [1:0]      o_result,
   output logic            o_done
);
   if (SETTLE < 1 || SETTLE > 65535) $error("window_monitor: SETTLE out of range");
   logic [15:0] wait_count;
   logic        busy;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         wait_count <= 16'h0000;
         busy       <= 1'b0;
         o_done     <= 1'b0;
         o_result   <= 2'h0;
      end
      else if (i_start)
      begin
         wait_count <= 16'(SETTLE - 1);
         busy       <= 1'b1;
         o_done     <= 1'b0;
      end
      else if (busy && wait_count == 16'h0000)
      begin
         busy     <= 1'b0;
         o_done   <= 1'b1;
         o_result <= i_window;
      end
      else if (busy)
      begin
         wait_count <= wait_count - 16'h0001;
      end
   end
endmodule
`default_nettype wire
